// *** hw/aes_pkg.sv ***
package aes_pkg;
   // ==========================================
   // Widths and map
   localparam int ACC_W = 40;
   localparam int TRN_W = 16;
   localparam logic [7:0] OFF_SRC1_LO = 8'h00;
   localparam logic [7:0] OFF_SRC1_HI = 8'h04;
   localparam logic [7:0] OFF_SRC2_LO = 8'h08;
   localparam logic [7:0] OFF_SRC2_HI = 8'h0C;
   localparam logic [7:0] OFF_CTRL = 8'h10;
   localparam logic [7:0] OFF_CMD = 8'h14;
   localparam logic [7:0] OFF_EXT_LO = 8'h18;
   localparam logic [7:0] OFF_EXT_HI = 8'h1C;
   localparam logic [7:0] OFF_DIFF_LO = 8'h20;
   localparam logic [7:0] OFF_DIFF_HI = 8'h24;
   localparam logic [7:0] OFF_TRN = 8'h28;
   localparam logic [7:0] OFF_STATUS = 8'h2C;
   // ==========================================
   // Field positions and reset values
   localparam int CTRL_WIDE_BIT = 0;
   localparam int CTRL_SAT_BIT = 1;
   localparam int CTRL_LEGACY_BIT = 2;
   localparam int CMD_OP_BIT = 0;
   localparam int CMD_SEL_BIT = 1;
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_CARRY_BIT = 1;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [15:0] TRN_RST = 16'h0000;
   // ==========================================
   // Saturation values and response codes
   localparam logic [15:0] SAT_LO_POS = 16'h7FFF;
   localparam logic [15:0] SAT_LO_NEG = 16'h8000;
   localparam logic [23:0] SAT_HI_POS = 24'h007FFF;
   localparam logic [23:0] SAT_HI_NEG = 24'hFF8000;
   localparam logic [39:0] SAT40_POS = 40'h7FFFFFFFFF;
   localparam logic [39:0] SAT40_NEG = 40'h8000000000;
   localparam logic [39:0] SAT32_POS = 40'h007FFFFFFF;
   localparam logic [39:0] SAT32_NEG = 40'hFF80000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================
   // Types
   typedef struct packed {
      logic [39:0] ext;
      logic [39:0] diff;
      logic dec_hi;
      logic dec_lo;
      logic ovf;
      logic carry;
   } aes_res_s;
   typedef enum logic [1:0] {AES_WR_COLLECT = 2'b01, AES_WR_RESP = 2'b10} aes_wr_e;
   typedef enum logic [1:0] {AES_RD_IDLE = 2'b01, AES_RD_DATA = 2'b10} aes_rd_e;
endpackage

// *** hw/aes_core.sv ***
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/100ps
// How it works
// - Dual mode splits into independent 16-bit low and 24-bit high paths.
// - Guard bits join the high path, spanning bits 39 to 16.
// - Dual min writes second minus first, high and low separately.
// - Low path overflow detected at bit 15.
// - High overflow at bit 31; either path sets the overflow flag, the low path only outside legacy.
// - Dual carry is the high path carry at bit 31.
// - Saturation on low overflow gives 7FFF or 8000.
// - Saturation on high overflow gives 007FFF or FF8000.
// - Sign bits are 15 for low and 31 for high comparison.
// - Both decision registers shift right; new bits at 15.
// - Decision 0 when first source wins, 1 otherwise.
// - Dual min picks first part only when strictly less.
// - Legacy dual min: no saturation, overflow only from high path.
// - Whole dual selection done in one cycle.
// - 40-bit max writes second minus first over 40 bits.
// - Narrow width compares bits 31-0, first wins only if greater.
// - Wide width compares all 40 bits; full source copied.
// - 40-bit max shifts the selected decision register, picked by command.
// - 40-bit max carry is the complement of the borrow.
// - Legacy 40-bit max compares as if wide width set.
module aes_core #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Decode looks at bits 7:2, so a narrower bus cannot reach the map
   if (ADDR_W < 8) begin : g_addr_check
      $error("ADDR_W must be at least 8");
   end

   // ==========================================
   // Storage
   logic [39:0] src1_r, src2_r, ext_r, diff_r;
   logic [2:0] ctrl_r;
   logic [15:0] trn_hi_r, trn_lo_r;
   logic ovf_r, carry_r;
   logic [7:0] waddr_r;
   logic wup_r, aw_have_r, w_have_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   aes_pkg::aes_wr_e wr_state_r;
   aes_pkg::aes_rd_e rd_state_r;
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;

   // ==========================================
   // Operand views
   wire [39:0] x = src1_r;
   wire [39:0] y = src2_r;
   wire wide = ctrl_r[aes_pkg::CTRL_WIDE_BIT];
   wire sat = ctrl_r[aes_pkg::CTRL_SAT_BIT];
   wire legacy = ctrl_r[aes_pkg::CTRL_LEGACY_BIT];

   // Dual path split, low 16 and high 24 bits
   wire [16:0] lo_sub = {1'b0, y[15:0]} - {1'b0, x[15:0]};
   wire [24:0] hi_sub = {1'b0, y[39:16]} - {1'b0, x[39:16]};
   wire [15:0] lo_raw = lo_sub[15:0];
   wire [23:0] hi_raw = hi_sub[23:0];
   wire lo_ov = (y[15] ^ x[15]) & (lo_raw[15] ^ y[15]);
   wire hi_ov = (y[31] ^ x[31]) & (hi_raw[15] ^ y[31]);
   wire lo_ov_eff = lo_ov & ~legacy;
   wire sat_dual = sat & ~legacy;
   wire [15:0] lo_sat = y[15] ? aes_pkg::SAT_LO_NEG : aes_pkg::SAT_LO_POS;
   wire [23:0] hi_sat = y[31] ? aes_pkg::SAT_HI_NEG : aes_pkg::SAT_HI_POS;
   wire [15:0] lo_diff = (sat_dual & lo_ov) ? lo_sat : lo_raw;
   wire [23:0] hi_diff = (sat_dual & hi_ov) ? hi_sat : hi_raw;
   wire dual_carry = (y[31:16] >= x[31:16]);
   // Signed compare on each path
   wire hi_take_x = $signed(x[31:16]) < $signed(y[31:16]);
   wire lo_take_x = $signed(x[15:0]) < $signed(y[15:0]);
   wire [23:0] hi_ext = hi_take_x ? x[39:16] : y[39:16];
   wire [15:0] lo_ext = lo_take_x ? x[15:0] : y[15:0];

   // Single 40-bit maximum
   wire [40:0] w_sub = {1'b0, y} - {1'b0, x};
   wire [39:0] w_raw = w_sub[39:0];
   // Legacy code compares at full width but keeps the narrow overflow rules
   wire cmp_wide = wide | legacy;
   wire max_take_x = cmp_wide ? ($signed(x) > $signed(y)) : ($signed(x[31:0]) > $signed(y[31:0]));
   wire ov40 = (y[39] ^ x[39]) & (w_raw[39] ^ y[39]);
   wire ov32 = (y[31] ^ x[31]) & (w_raw[31] ^ y[31]);
   wire max_ov = wide ? ov40 : ov32;
   wire [39:0] sat_n = y[31] ? aes_pkg::SAT32_NEG : aes_pkg::SAT32_POS;
   wire [39:0] sat_w = y[39] ? aes_pkg::SAT40_NEG : aes_pkg::SAT40_POS;
   wire [39:0] max_diff = (sat & max_ov) ? (wide ? sat_w : sat_n) : w_raw;

   // Result selection by command
   wire cmd_max = wdata_r[aes_pkg::CMD_OP_BIT];
   wire cmd_sel = wdata_r[aes_pkg::CMD_SEL_BIT];
   aes_pkg::aes_res_s res;
   assign res.ext = cmd_max ? (max_take_x ? x : y) : {hi_ext, lo_ext};
   assign res.diff = cmd_max ? max_diff : {hi_diff, lo_diff};
   assign res.dec_hi = cmd_max ? ~max_take_x : ~hi_take_x;
   assign res.dec_lo = ~lo_take_x;
   assign res.ovf = cmd_max ? max_ov : (hi_ov | lo_ov_eff);
   assign res.carry = cmd_max ? ~w_sub[40] : dual_carry;

   // ==========================================
   // Write channel handshake
   wire aw_take = s_axi_awvalid & awready_r;
   wire w_take = s_axi_wvalid & wready_r;
   // Commit waits for both halves; their order of arrival is free
   wire commit = aw_have_r & w_have_r & (wr_state_r == aes_pkg::AES_WR_COLLECT);
   wire resp_done = bvalid_r & s_axi_bready;
   wire aw_have_nxt = (aw_have_r & ~commit) | aw_take;
   wire w_have_nxt = (w_have_r & ~commit) | w_take;
   wire bvalid_nxt = commit | (bvalid_r & ~resp_done);
   wire [7:0] awa = {s_axi_awaddr[7:2], 2'b00};
   wire awup = (s_axi_awaddr >> 8) == 0;
   wire hit = (waddr_r <= aes_pkg::OFF_STATUS) & wup_r;
   wire we = commit & hit;
   wire we_s1l = we & (waddr_r == aes_pkg::OFF_SRC1_LO);
   wire we_s1h = we & (waddr_r == aes_pkg::OFF_SRC1_HI);
   wire we_s2l = we & (waddr_r == aes_pkg::OFF_SRC2_LO);
   wire we_s2h = we & (waddr_r == aes_pkg::OFF_SRC2_HI);
   wire we_ctrl = we & (waddr_r == aes_pkg::OFF_CTRL);
   wire we_trn = we & (waddr_r == aes_pkg::OFF_TRN);
   wire we_stat = we & (waddr_r == aes_pkg::OFF_STATUS);
   wire fire = we & (waddr_r == aes_pkg::OFF_CMD) & wstrb_r[0];

   // Old value of the targeted register
   wire [31:0] old_w = we_s1l ? src1_r[31:0] : we_s1h ? {24'h000000, src1_r[39:32]} :
                       we_s2l ? src2_r[31:0] : we_s2h ? {24'h000000, src2_r[39:32]} :
                       we_ctrl ? {29'h00000000, ctrl_r} : {trn_lo_r, trn_hi_r};
   wire [31:0] merged;
   genvar gi;
   // Byte lane merge under strobes
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign merged[8*gi +: 8] = wstrb_r[gi] ? wdata_r[8*gi +: 8] : old_w[8*gi +: 8];
      end
   endgenerate

   // Decision register next values
   wire [15:0] trn_hi_sh = {res.dec_hi, trn_hi_r[15:1]};
   wire [15:0] trn_lo_sh = {(cmd_max ? res.dec_hi : res.dec_lo), trn_lo_r[15:1]};
   wire shift_hi = fire & (~cmd_max | ~cmd_sel);
   wire shift_lo = fire & (~cmd_max | cmd_sel);
   // Set beats clear, so an overflow is never lost to a late clear
   wire ovf_clr = we_stat & wstrb_r[0] & wdata_r[aes_pkg::STAT_OVF_BIT];
   wire ovf_nxt = (fire & res.ovf) | (ovf_r & ~ovf_clr);

   // ==========================================
   // Read decode
   wire [7:0] ara = {s_axi_araddr[7:2], 2'b00};
   wire arup = (s_axi_araddr >> 8) == 0;
   wire rhit = arup & (ara <= aes_pkg::OFF_STATUS);
   wire [31:0] rd_mux = (ara == aes_pkg::OFF_SRC1_LO) ? src1_r[31:0] :
                        (ara == aes_pkg::OFF_SRC1_HI) ? {24'h000000, src1_r[39:32]} :
                        (ara == aes_pkg::OFF_SRC2_LO) ? src2_r[31:0] :
                        (ara == aes_pkg::OFF_SRC2_HI) ? {24'h000000, src2_r[39:32]} :
                        (ara == aes_pkg::OFF_CTRL) ? {29'h00000000, ctrl_r} :
                        (ara == aes_pkg::OFF_EXT_LO) ? ext_r[31:0] :
                        (ara == aes_pkg::OFF_EXT_HI) ? {24'h000000, ext_r[39:32]} :
                        (ara == aes_pkg::OFF_DIFF_LO) ? diff_r[31:0] :
                        (ara == aes_pkg::OFF_DIFF_HI) ? {24'h000000, diff_r[39:32]} :
                        (ara == aes_pkg::OFF_TRN) ? {trn_lo_r, trn_hi_r} :
                        (ara == aes_pkg::OFF_STATUS) ? {30'h00000000, carry_r, ovf_r} : 32'h00000000;
   wire ar_take = s_axi_arvalid & arready_r;
   wire r_done = rvalid_r & s_axi_rready;

   // ==========================================
   // Write channel flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= aes_pkg::RESP_OKAY;
         waddr_r <= 8'h00;
         wup_r <= 1'b0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         wr_state_r <= aes_pkg::AES_WR_COLLECT;
      end else begin
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         awready_r <= ~aw_have_nxt & ~bvalid_nxt;
         wready_r <= ~w_have_nxt & ~bvalid_nxt;
         bvalid_r <= bvalid_nxt;
         if (aw_take) begin
            waddr_r <= awa;
            wup_r <= awup;
         end
         if (w_take) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         case (wr_state_r)
            aes_pkg::AES_WR_COLLECT: begin
               if (commit) begin
                  wr_state_r <= aes_pkg::AES_WR_RESP;
                  bresp_r <= hit ? aes_pkg::RESP_OKAY : aes_pkg::RESP_SLVERR;
               end
            end
            aes_pkg::AES_WR_RESP: begin
               if (resp_done) wr_state_r <= aes_pkg::AES_WR_COLLECT;
            end
            default: wr_state_r <= aes_pkg::AES_WR_COLLECT;
         endcase
      end
   end

   // Operand and control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src1_r <= 40'h0000000000;
         src2_r <= 40'h0000000000;
         ctrl_r <= aes_pkg::CTRL_RST;
      end else begin
         if (we_s1l) src1_r[31:0] <= merged;
         if (we_s1h) src1_r[39:32] <= merged[7:0];
         if (we_s2l) src2_r[31:0] <= merged;
         if (we_s2h) src2_r[39:32] <= merged[7:0];
         if (we_ctrl) ctrl_r <= merged[2:0];
      end
   end

   // Results: sources are read in the same edge that stores them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_r <= 40'h0000000000;
         diff_r <= 40'h0000000000;
         carry_r <= 1'b0;
         ovf_r <= 1'b0;
         trn_hi_r <= aes_pkg::TRN_RST;
         trn_lo_r <= aes_pkg::TRN_RST;
      end else begin
         ovf_r <= ovf_nxt;
         if (fire) begin
            ext_r <= res.ext;
            diff_r <= res.diff;
            carry_r <= res.carry;
         end
         if (we_trn) begin
            trn_hi_r <= merged[15:0];
            trn_lo_r <= merged[31:16];
         end else begin
            if (shift_hi) trn_hi_r <= trn_hi_sh;
            if (shift_lo) trn_lo_r <= trn_lo_sh;
         end
      end
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_r <= aes_pkg::AES_RD_IDLE;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= aes_pkg::RESP_OKAY;
      end else begin
         case (rd_state_r)
            aes_pkg::AES_RD_IDLE: begin
               arready_r <= ~ar_take;
               if (ar_take) begin
                  rd_state_r <= aes_pkg::AES_RD_DATA;
                  rvalid_r <= 1'b1;
                  rdata_r <= rd_mux;
                  rresp_r <= rhit ? aes_pkg::RESP_OKAY : aes_pkg::RESP_SLVERR;
               end
            end
            aes_pkg::AES_RD_DATA: begin
               if (r_done) begin
                  rd_state_r <= aes_pkg::AES_RD_IDLE;
                  rvalid_r <= 1'b0;
                  arready_r <= 1'b1;
               end
            end
            default: rd_state_r <= aes_pkg::AES_RD_IDLE;
         endcase
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ==========================================
   // Checks
   // Results are checked one edge after the command commits
   wire dual_f = fire & ~cmd_max;
   wire max_f = fire & cmd_max;
   a_dual_diff: assert property (@(posedge aclk) disable iff (!aresetn)
      dual_f && !sat |=> diff_r == {$past(hi_raw), $past(lo_raw)})
      else $error("dual difference wrong");
   a_lo_sat: assert property (@(posedge aclk) disable iff (!aresetn)
      dual_f && sat && !legacy && lo_ov |=> diff_r[15:0] == ($past(y[15]) ? 16'h8000 : 16'h7FFF))
      else $error("low saturation wrong");
   a_hi_sat: assert property (@(posedge aclk) disable iff (!aresetn)
      dual_f && sat && !legacy && hi_ov |=> diff_r[39:16] == ($past(y[31]) ? 24'hFF8000 : 24'h007FFF))
      else $error("high saturation wrong");
   a_legacy_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
      dual_f && legacy && !ovf_r && !hi_ov |=> !ovf_r && diff_r[15:0] == $past(lo_raw))
      else $error("legacy dual overflow wrong");
   a_ovf_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      fire && res.ovf |=> ovf_r)
      else $error("overflow flag not set");
   a_dual_carry: assert property (@(posedge aclk) disable iff (!aresetn)
      dual_f |=> carry_r == ($past(y[31:16]) >= $past(x[31:16])))
      else $error("dual carry wrong");
   a_min_pick: assert property (@(posedge aclk) disable iff (!aresetn)
      dual_f |=> trn_hi_r[15] == ($signed($past(x[31:16])) >= $signed($past(y[31:16])))
         && ext_r[39:16] == (trn_hi_r[15] ? $past(y[39:16]) : $past(x[39:16])))
      else $error("min decision mismatch");
   a_min_low: assert property (@(posedge aclk) disable iff (!aresetn)
      dual_f |=> trn_lo_r[15] == ($signed($past(x[15:0])) >= $signed($past(y[15:0])))
         && ext_r[15:0] == (trn_lo_r[15] ? $past(y[15:0]) : $past(x[15:0])))
      else $error("low min decision mismatch");
   a_lo_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
      dual_f && !legacy && (y[15] != x[15]) && (lo_raw[15] != y[15]) |=> ovf_r)
      else $error("low overflow not reported");
   a_trn_shift: assert property (@(posedge aclk) disable iff (!aresetn)
      dual_f |=> trn_hi_r[14:0] == $past(trn_hi_r[15:1]) && trn_lo_r[14:0] == $past(trn_lo_r[15:1]))
      else $error("decision shift wrong");
   a_max_wide: assert property (@(posedge aclk) disable iff (!aresetn)
      max_f && legacy |=> ext_r == (($signed($past(x)) > $signed($past(y))) ? $past(x) : $past(y)))
      else $error("wide max selection wrong");
   a_max_carry: assert property (@(posedge aclk) disable iff (!aresetn)
      max_f |=> carry_r == ($past(y) >= $past(x)))
      else $error("max carry wrong");
   a_max_diff: assert property (@(posedge aclk) disable iff (!aresetn)
      max_f && !sat |=> diff_r == $past(y) - $past(x))
      else $error("max difference wrong");
   a_max_narrow: assert property (@(posedge aclk) disable iff (!aresetn)
      max_f && !wide && !legacy
      |=> ext_r == (($signed($past(x[31:0])) > $signed($past(y[31:0]))) ? $past(x) : $past(y)))
      else $error("narrow max selection wrong");
   a_max_shift: assert property (@(posedge aclk) disable iff (!aresetn)
      max_f && cmd_sel |=> trn_lo_r[14:0] == $past(trn_lo_r[15:1]) && trn_hi_r == $past(trn_hi_r))
      else $error("selected decision shift wrong");
   a_max_sat: assert property (@(posedge aclk) disable iff (!aresetn)
      max_f && sat && wide && ov40 |=> diff_r == ($past(y[39]) ? 40'h8000000000 : 40'h7FFFFFFFFF))
      else $error("wide max saturation wrong");
   a_bresp_soon: assert property (@(posedge aclk) disable iff (!aresetn)
      commit |=> bvalid_r)
      else $error("write response late");
   c_dual: cover property (@(posedge aclk) disable iff (!aresetn) dual_f && hi_ov && lo_ov);
   c_max_sel: cover property (@(posedge aclk) disable iff (!aresetn) max_f && cmd_sel);
   c_max_sat: cover property (@(posedge aclk) disable iff (!aresetn) max_f && sat && max_ov);
   c_legacy: cover property (@(posedge aclk) disable iff (!aresetn) dual_f && legacy);
endmodule

// *** verif/aes_host.sv ***
`timescale 1ns/100ps
// ==========================================
// Bus master standing in for the instruction decoder
module aes_host (
   input wire logic aclk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // Idle bus from time zero
   initial begin
      awaddr = 8'h00;
      awvalid = 1'b0;
      wdata = 32'h00000000;
      wstrb = 4'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 8'h00;
      arvalid = 1'b0;
      rready = 1'b0;
   end

   // Write: both channels offered, each released at its own take
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] resp);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
            awaddr <= ~a; // Released payload must not look valid
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      do @(posedge aclk); while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
      @(posedge aclk); // Keeps release and next request in separate steps
   endtask

   // Read: address held until taken, data taken with rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      araddr <= ~a;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
endmodule

// *** verif/test_accumulator_extremum_select.sv ***
`timescale 1ns/100ps
// ==========================================
// Self-checking bench for the extremum select block
module test_accumulator_extremum_select;
   typedef struct packed {
      logic [39:0] x;
      logic [39:0] y;
      logic [2:0] ctrl;
      logic [1:0] cmd;
      logic [39:0] ext;
      logic [39:0] diff;
      logic [31:0] trn;
      logic [1:0] stat;
   } aes_case_s;
   localparam int LIMIT = 20000;
   logic aclk;
   logic aresetn;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   aes_case_s cases [14];

   // ==========================================
   // Design and bus master
   aes_core #(.ADDR_W(8)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   aes_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));

   // 100 MHz clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Hang guard
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors++;
         wrap_up();
      end
   end

   // ==========================================
   // Comparisons and bus helpers
   task automatic chk_data(input string what, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected data at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_resp(input string what, input logic [1:0] got, input logic [1:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected response at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
      host.rd(a, rv, rsp);
      chk_data(what, rv, exp);
      chk_resp(what, rsp, er);
   endtask
   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      host.wr(a, d, 4'hF, rsp);
      chk_resp("write", rsp, aes_pkg::RESP_OKAY);
   endtask

   // One operation: clear flag, seed decisions, load, fire, read all results
   task automatic run_case(input aes_case_s c);
      wr_ok(aes_pkg::OFF_STATUS, 32'h00000001);
      wr_ok(aes_pkg::OFF_TRN, 32'h00400800);
      wr_ok(aes_pkg::OFF_SRC1_LO, c.x[31:0]);
      wr_ok(aes_pkg::OFF_SRC1_HI, {24'h000000, c.x[39:32]});
      wr_ok(aes_pkg::OFF_SRC2_LO, c.y[31:0]);
      wr_ok(aes_pkg::OFF_SRC2_HI, {24'h000000, c.y[39:32]});
      wr_ok(aes_pkg::OFF_CTRL, {29'h00000000, c.ctrl});
      wr_ok(aes_pkg::OFF_CMD, {30'h00000000, c.cmd});
      rd_chk(aes_pkg::OFF_EXT_LO, c.ext[31:0], aes_pkg::RESP_OKAY, "ext_lo");
      rd_chk(aes_pkg::OFF_EXT_HI, {24'h000000, c.ext[39:32]}, aes_pkg::RESP_OKAY, "ext_hi");
      rd_chk(aes_pkg::OFF_DIFF_LO, c.diff[31:0], aes_pkg::RESP_OKAY, "diff_lo");
      rd_chk(aes_pkg::OFF_DIFF_HI, {24'h000000, c.diff[39:32]}, aes_pkg::RESP_OKAY, "diff_hi");
      rd_chk(aes_pkg::OFF_TRN, c.trn, aes_pkg::RESP_OKAY, "decisions");
      rd_chk(aes_pkg::OFF_STATUS, {30'h00000000, c.stat}, aes_pkg::RESP_OKAY, "status");
   endtask

   task automatic wrap_up();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial begin
      aresetn = 1'b0;
      cases = '{
         '{40'h1024002222, 40'h008000DDDE, 3'h2, 2'h0, 40'h008000DDDE, 40'hFF8000BBBC, 32'h80208400, 2'h3},
         '{40'h1024002222, 40'h008000DDDE, 3'h6, 2'h0, 40'h008000DDDE, 40'hF05C00BBBC, 32'h80208400, 2'h3},
         '{40'h0000000001, 40'h0000008000, 3'h2, 2'h0, 40'h0000008000, 40'h0000008000, 32'h80208400, 2'h3},
         '{40'h0000000001, 40'h0000008000, 3'h6, 2'h0, 40'h0000008000, 40'h0000007FFF, 32'h80208400, 2'h2},
         '{40'h0000000001, 40'h0000008000, 3'h0, 2'h0, 40'h0000008000, 40'h0000007FFF, 32'h80208400, 2'h3},
         '{40'h0000008000, 40'h0000000001, 3'h2, 2'h0, 40'h0000008000, 40'h0000007FFF, 32'h00208400, 2'h3},
         '{40'h0080000000, 40'h007FFF0000, 3'h2, 2'h0, 40'h0080000000, 40'h007FFF0000, 32'h80200400, 2'h1},
         '{40'h1024002222, 40'h008000DDDE, 3'h3, 2'h3, 40'h1024002222, 40'hF05C00BBBC, 32'h00200800, 2'h0},
         '{40'h1024002222, 40'h008000DDDE, 3'h2, 2'h1, 40'h1024002222, 40'hFF80000000, 32'h00400400, 2'h1},
         '{40'h0100000000, 40'h0000000001, 3'h0, 2'h1, 40'h0000000001, 40'hFF00000001, 32'h00408400, 2'h0},
         '{40'h0100000000, 40'h0000000001, 3'h4, 2'h3, 40'h0100000000, 40'hFF00000001, 32'h00200800, 2'h0},
         '{40'h0100000000, 40'h0000000001, 3'h1, 2'h1, 40'h0100000000, 40'hFF00000001, 32'h00400400, 2'h0},
         '{40'h8000000000, 40'h0000000001, 3'h3, 2'h1, 40'h0000000001, 40'h7FFFFFFFFF, 32'h00408400, 2'h1},
         '{40'h0000000001, 40'h0000000002, 3'h1, 2'h3, 40'h0000000002, 40'h0000000001, 32'h80200800, 2'h2}
      };
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      // Reset values and unmapped space
      for (int a = 0; a < 48; a += 4) begin
         rd_chk(8'(a), 32'h00000000, aes_pkg::RESP_OKAY, "reset value");
      end
      rd_chk(8'h30, 32'h00000000, aes_pkg::RESP_SLVERR, "unmapped read");
      host.wr(8'hFC, 32'hFFFFFFFF, 4'hF, rsp);
      chk_resp("unmapped write", rsp, aes_pkg::RESP_SLVERR);
      // Byte enables
      wr_ok(aes_pkg::OFF_SRC1_LO, 32'h11223344);
      host.wr(aes_pkg::OFF_SRC1_LO, 32'hAABBCCDD, 4'h2, rsp);
      chk_resp("strobe write", rsp, aes_pkg::RESP_OKAY);
      rd_chk(aes_pkg::OFF_SRC1_LO, 32'h1122CC44, aes_pkg::RESP_OKAY, "strobe");
      // Operation table
      foreach (cases[i]) begin
         run_case(cases[i]);
      end
      // Repeat without reload: sources intact, decision shifts again
      wr_ok(aes_pkg::OFF_CMD, 32'h00000003);
      rd_chk(aes_pkg::OFF_TRN, 32'hC0100800, aes_pkg::RESP_OKAY, "repeat decisions");
      rd_chk(aes_pkg::OFF_EXT_LO, 32'h00000002, aes_pkg::RESP_OKAY, "repeat ext");
      rd_chk(aes_pkg::OFF_SRC2_LO, 32'h00000002, aes_pkg::RESP_OKAY, "source kept");
      wrap_up();
   end
endmodule
